// ==== rtl/shaft_access_pkg.sv ====
// constants, register map and carrier types of the shaft access interlock
package shaft_access_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned QUICK_GAP_MS   = 1000;
  localparam int unsigned QUICK_GAP_CYC  = CLK_HZ / 1000 * QUICK_GAP_MS;
  localparam int unsigned COIL_PULSE_MS  = 200;
  localparam int unsigned COIL_PULSE_CYC = CLK_HZ / 1000 * COIL_PULSE_MS;
  localparam int unsigned QUICK_PULSES   = 3;

  // fault codes
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_PIT  = 8'h14;
  localparam logic [7:0] CODE_KEY  = 8'h15;
  localparam logic [7:0] CODE_COIL = 8'h79;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_GAP    = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // field positions
  localparam int unsigned CTRL_MONO_BIT  = 0;
  localparam int unsigned CMD_RESET_BIT  = 0;
  localparam int unsigned STAT_FAULT_BIT = 0;
  localparam int unsigned STAT_CODE_LSB  = 8;
  localparam int unsigned STAT_GREEN_BIT = 16;
  localparam int unsigned STAT_COIL_BIT  = 17;
  localparam int unsigned STAT_RUN_BIT   = 18;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // shaft side contacts, all from pins
  typedef struct packed {
    logic pit_chain_point_open;
    logic key_open;
    logic reset_button;
    logic bistable_open;
    logic internal_bist_open;
    logic doors_closed;
    logic chain_closed;
    logic car_stopped;
  } shaft_pins_t;

  // run control requests, same clock
  typedef struct packed {
    logic normal_req;
    logic inspection_req;
    logic inspection_mode;
  } run_req_t;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'b00,
    ST_FAULT = 2'b01,
    ST_COIL  = 2'b10
  } guard_state_t;

endpackage

// ==== rtl/pulse_train_detect.sv ====
// counts quick pulses whose gaps stay under a maximum
`timescale 1ns/1ps
module pulse_train_detect #(
  parameter int unsigned PULSES = shaft_access_pkg::QUICK_PULSES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        arm,
  input  wire logic        pulse,
  input  wire logic [31:0] gap_max,
  output logic             done
);

  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [31:0] gap_r;
  logic [31:0] gap_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        late;

  // a gap that reaches the limit breaks the train
  assign late = (cnt_r != 4'h0) && (gap_r >= gap_max);

  // next count, gap timer and completion
  always_comb begin
    cnt_nxt  = cnt_r;
    gap_nxt  = gap_r;
    done_nxt = 1'b0;
    if (!arm) begin
      cnt_nxt = 4'h0;
      gap_nxt = 32'h0000_0000;
    end else if (pulse) begin
      // the pulse cycle is the first cycle of the next gap, so a gap equal to the limit breaks the train
      gap_nxt = 32'h0000_0001;
      if (late || cnt_r == 4'h0) begin
        cnt_nxt = 4'h1;
      end else if (cnt_r == 4'(PULSES - 1)) begin
        cnt_nxt  = 4'h0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end else if (late) begin
      cnt_nxt = 4'h0;
    end else if (cnt_r != 4'h0) begin
      gap_nxt = gap_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= 4'h0;
      gap_r  <= 32'h0000_0000;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      gap_r  <= gap_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;

  a_gap_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    arm && late && !pulse |=> cnt_r == 4'h0)
    else $error("late pulse train not restarted");

endmodule

// ==== rtl/shaft_access_interlock.sv ====
// shaft access interlock with AHB-Lite register slave
//
// Behaviour
// - pit chain point open latches code 20
// - release key opening latches code 21
// - fault blocks normal runs, inspection allowed
// - green light only when shaft safe
// - three quick key cycles clear fault
// - three quick button presses clear fault
// - handheld programmer reset command clears fault
// - reset needs doors and chain closed
// - reset needs bistable contacts open in bistable mode
// - early bistable closure raises code 121 in bistable mode
// - reset energises landing reset coils
// - monostable mode: internal circuit must be open
`timescale 1ns/1ps
module shaft_access_interlock #(
  parameter logic [31:0] QUICK_GAP_CYC  = 32'(shaft_access_pkg::QUICK_GAP_CYC),
  parameter logic [31:0] COIL_PULSE_CYC = 32'(shaft_access_pkg::COIL_PULSE_CYC)
) (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire shaft_access_pkg::shaft_pins_t pins,
  input  wire shaft_access_pkg::run_req_t    run_req,
  output logic                               run_permit,
  output logic                               shaft_protection_fault,
  output logic      [7:0]                    fault_code,
  output logic                               green_light,
  output logic                               red_light,
  output logic                               reset_coil
);

  localparam int PW = $bits(shaft_access_pkg::shaft_pins_t);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edges

  logic [PW-1:0] sync1_r;
  logic [PW-1:0] sync2_r;
  logic [PW-1:0] prev_r;

  // contacts bounce and come from another domain, so two flops each
  for (genvar i = 0; i < PW; i++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync1_r[i] <= 1'b0;
        sync2_r[i] <= 1'b0;
        prev_r[i]  <= 1'b0;
      end else begin
        sync1_r[i] <= pins[i];
        sync2_r[i] <= sync1_r[i];
        prev_r[i]  <= sync2_r[i];
      end
    end
  end

  shaft_access_pkg::shaft_pins_t pin_s;
  shaft_access_pkg::shaft_pins_t pin_p;
  assign pin_s = sync2_r;
  assign pin_p = prev_r;

  logic pit_rise;
  logic key_rise;
  logic key_fall;
  logic btn_rise;
  logic bist_rise;
  logic bist_fall;

  // edge detectors read only the settled copies
  assign pit_rise  = pin_s.pit_chain_point_open & ~pin_p.pit_chain_point_open;
  assign key_rise  = pin_s.key_open & ~pin_p.key_open;
  assign key_fall  = ~pin_s.key_open & pin_p.key_open;
  assign btn_rise  = pin_s.reset_button & ~pin_p.reset_button;
  assign bist_rise = pin_s.bistable_open & ~pin_p.bistable_open;
  assign bist_fall = ~pin_s.bistable_open & pin_p.bistable_open;

  //////////////////////////////////////////////////////////////////////////////
  // register slave

  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [7:0]  waddr_r;
  logic [7:0]  waddr_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] gap_r;
  logic [31:0] gap_nxt;
  logic        cmd_r;
  logic        cmd_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] status_w;
  logic        addr_phase;

  logic                                fault_r;
  logic [7:0]                          code_r;
  logic                                green_r;
  logic                                coil_r;
  logic                                permit_r;
  shaft_access_pkg::guard_state_t      state_r;

  assign addr_phase = hsel & hready & htrans[1];

  // status word shows the block's own state
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[shaft_access_pkg::STAT_FAULT_BIT] = fault_r;
    status_w[shaft_access_pkg::STAT_CODE_LSB +: 8] = code_r;
    status_w[shaft_access_pkg::STAT_GREEN_BIT] = green_r;
    status_w[shaft_access_pkg::STAT_COIL_BIT] = coil_r;
    status_w[shaft_access_pkg::STAT_RUN_BIT] = permit_r;
  end

  // read data is captured in the address phase so it leaves a flop
  always_comb begin
    wr_pend_nxt = addr_phase & hwrite;
    waddr_nxt   = addr_phase ? haddr[7:0] : waddr_r;
    ctrl_nxt    = ctrl_r;
    gap_nxt     = gap_r;
    cmd_nxt     = 1'b0;
    rdata_nxt   = rdata_r;
    if (wr_pend_r) begin
      case (waddr_r)
        shaft_access_pkg::ADDR_CTRL: begin
          ctrl_nxt = {31'h0000_0000, hwdata[shaft_access_pkg::CTRL_MONO_BIT]};
        end
        shaft_access_pkg::ADDR_GAP: begin
          gap_nxt = hwdata;
        end
        shaft_access_pkg::ADDR_CMD: begin
          cmd_nxt = hwdata[shaft_access_pkg::CMD_RESET_BIT];
        end
        default: begin
        end
      endcase
    end
    if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        shaft_access_pkg::ADDR_CTRL:   rdata_nxt = ctrl_r;
        shaft_access_pkg::ADDR_GAP:    rdata_nxt = gap_r;
        shaft_access_pkg::ADDR_STATUS: rdata_nxt = status_w;
        default:                       rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      waddr_r   <= 8'h00;
      ctrl_r    <= shaft_access_pkg::CTRL_RST;
      gap_r     <= QUICK_GAP_CYC;
      cmd_r     <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      waddr_r   <= waddr_nxt;
      ctrl_r    <= ctrl_nxt;
      gap_r     <= gap_nxt;
      cmd_r     <= cmd_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // zero wait states, always OKAY; hsize is word only
  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // reset path detectors

  logic key_done;
  logic btn_done;
  logic armed;

  // trains are only counted while a fault waits for its reset
  assign armed = (state_r == shaft_access_pkg::ST_FAULT);

  // an open-then-close of the key counts on the close
  pulse_train_detect u_key_train (
    .hclk    (hclk),
    .hresetn (hresetn),
    .arm     (armed),
    .pulse   (key_fall),
    .gap_max (gap_r),
    .done    (key_done)
  );

  pulse_train_detect u_btn_train (
    .hclk    (hclk),
    .hresetn (hresetn),
    .arm     (armed),
    .pulse   (btn_rise),
    .gap_max (gap_r),
    .done    (btn_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // fault state machine

  logic                           mono;
  logic                           contacts_open;
  logic                           access_evt;
  logic [7:0]                     access_code;
  logic                           early_close;
  logic                           rst_req;
  logic                           ready_ok;
  logic                           accept;
  logic [31:0]                    coil_cnt_r;
  logic [31:0]                    coil_cnt_nxt;
  logic [7:0]                     code_nxt;
  shaft_access_pkg::guard_state_t state_nxt;

  assign mono          = ctrl_r[shaft_access_pkg::CTRL_MONO_BIT];
  assign contacts_open = mono ? pin_s.internal_bist_open : pin_s.bistable_open;
  // in bistable mode the contact itself also reports entry
  assign access_evt    = pit_rise | key_rise | (~mono & bist_rise);
  assign access_code   = pit_rise ? shaft_access_pkg::CODE_PIT : shaft_access_pkg::CODE_KEY;
  assign early_close   = armed & ~mono & bist_fall;
  assign rst_req       = key_done | btn_done | cmd_r;
  assign ready_ok      = pin_s.doors_closed & pin_s.chain_closed & contacts_open;
  // a new entry in the same cycle as a reset wins over the clear
  assign accept        = rst_req & ready_ok & ~access_evt & ~early_close;

  always_comb begin
    state_nxt    = state_r;
    code_nxt     = code_r;
    coil_cnt_nxt = coil_cnt_r;
    case (state_r)
      shaft_access_pkg::ST_CLEAR: begin
        if (access_evt) begin
          state_nxt = shaft_access_pkg::ST_FAULT;
          code_nxt  = access_code;
        end
      end
      shaft_access_pkg::ST_FAULT: begin
        if (early_close) begin
          code_nxt = shaft_access_pkg::CODE_COIL;
        end else if (accept) begin
          state_nxt    = shaft_access_pkg::ST_COIL;
          code_nxt     = shaft_access_pkg::CODE_NONE;
          coil_cnt_nxt = COIL_PULSE_CYC - 32'h0000_0001;
        end else if (rst_req && mono && !pin_s.internal_bist_open) begin
          code_nxt = shaft_access_pkg::CODE_COIL;
        end
        // otherwise the fault simply holds
      end
      shaft_access_pkg::ST_COIL: begin
        if (access_evt) begin
          state_nxt = shaft_access_pkg::ST_FAULT;
          code_nxt  = access_code;
        end else if (coil_cnt_r == 32'h0000_0000) begin
          state_nxt = shaft_access_pkg::ST_CLEAR;
        end else begin
          coil_cnt_nxt = coil_cnt_r - 32'h0000_0001;
        end
      end
      default: begin
        state_nxt = shaft_access_pkg::ST_FAULT;
        code_nxt  = shaft_access_pkg::CODE_KEY;
      end
    endcase
  end

  logic fault_nxt;
  logic green_nxt;
  logic coil_nxt;
  logic permit_nxt;

  // fault and coil outputs register the next state; green and run permit follow the present fault latch, one cycle late, harmless for relays
  always_comb begin
    fault_nxt  = (state_nxt == shaft_access_pkg::ST_FAULT);
    coil_nxt   = (state_nxt == shaft_access_pkg::ST_COIL);
    green_nxt  = fault_r & pin_s.car_stopped;
    permit_nxt = (run_req.inspection_req & run_req.inspection_mode) |
                 (run_req.normal_req & ~run_req.inspection_mode & ~fault_r);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= shaft_access_pkg::ST_CLEAR;
      code_r     <= shaft_access_pkg::CODE_NONE;
      coil_cnt_r <= 32'h0000_0000;
      fault_r    <= 1'b0;
      green_r    <= 1'b0;
      coil_r     <= 1'b0;
      permit_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      code_r     <= code_nxt;
      coil_cnt_r <= coil_cnt_nxt;
      fault_r    <= fault_nxt;
      green_r    <= green_nxt;
      coil_r     <= coil_nxt;
      permit_r   <= permit_nxt;
    end
  end

  assign shaft_protection_fault = fault_r;
  assign fault_code             = code_r;
  assign green_light            = green_r;
  assign red_light              = ~green_r;
  assign reset_coil             = coil_r;
  assign run_permit             = permit_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_accept;
    armed && accept;
  endsequence

  sequence s_enter_coil;
    armed ##1 state_r == shaft_access_pkg::ST_COIL;
  endsequence

  a_pit_code_20: assert property (
    state_r == shaft_access_pkg::ST_CLEAR && pit_rise |=> state_r == shaft_access_pkg::ST_FAULT
      ##1 fault_r && code_r == 8'h14)
    else $error("pit entry did not latch code 20");

  a_key_code_21: assert property (
    state_r == shaft_access_pkg::ST_CLEAR && key_rise && !pit_rise |=> code_r == 8'h15)
    else $error("key entry did not latch code 21");

  a_normal_run_blocked: assert property (
    fault_r && !run_req.inspection_req |=> !run_permit)
    else $error("run permitted during fault");

  a_green_safe_only: assert property (
    green_light |-> $past(fault_r) && $past(pin_s.car_stopped))
    else $error("green shown while shaft unsafe");

  a_key_train_clears: assert property (
    armed && key_done && accept |=> state_r == shaft_access_pkg::ST_COIL ##1 !fault_r)
    else $error("key train did not clear fault");

  a_btn_train_clears: assert property (
    armed && btn_done && accept |=> !armed)
    else $error("button train did not clear fault");

  a_cmd_clears: assert property (
    armed && cmd_r && ready_ok && !access_evt && !early_close |=> coil_r ##1 !fault_r)
    else $error("programmer reset did not clear fault");

  a_reset_needs_doors: assert property (
    armed && !(pin_s.doors_closed && pin_s.chain_closed) |=> armed)
    else $error("reset accepted with doors or chain open");

  a_reset_needs_open: assert property (
    armed && !contacts_open |=> armed)
    else $error("reset accepted with contacts closed");

  a_early_close_121: assert property (
    armed && !mono && bist_fall |=> armed && code_r == 8'h79)
    else $error("early contact closure did not give code 121");

  a_coil_pulse: assert property (
    s_accept |=> reset_coil [*8])
    else $error("reset coils not energised after reset");

  a_coil_after_clear: assert property (
    s_enter_coil |-> coil_r)
    else $error("coil state without coil drive");

  a_mono_refused: assert property (
    armed && mono && rst_req && !pin_s.internal_bist_open && !access_evt |=> armed && code_r == 8'h79)
    else $error("monostable reset with closed circuit not refused");

  a_fault_holds: assert property (
    armed && !rst_req |=> armed && fault_r)
    else $error("fault dropped without reset");

endmodule

// ==== dv/shaft_side_model.sv ====
// behavioural model of the shaft side: landing contacts, pit switch, chain, bistable contacts
`timescale 1ns/1ps
module shaft_side_model (
  input  wire logic                     hclk,
  input  wire logic                     reset_coil,
  output shaft_access_pkg::shaft_pins_t pins
);
  shaft_access_pkg::shaft_pins_t drv;
  logic                          bist_r;

  ////////////////////////////////////////////////////////////////////////////////
  // idle shaft: doors and chain closed, car at rest, all access contacts shut
  initial begin
    drv = shaft_access_pkg::shaft_pins_t'(8'h07);
    bist_r = 1'b0;
  end

  // the bistable contact latches open with the key; only the coil shuts it again,
  // the bench may also move it to mimic a faulty coil circuit or a technician
  always @(posedge hclk) begin
    if (reset_coil === 1'b1)
      bist_r <= 1'b0;
    else if (drv.key_open)
      bist_r <= 1'b1;
  end

  always_comb begin
    pins = drv;
    pins.bistable_open = bist_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // n pulses of key or button, three cycles wide so the pin synchroniser sees them,
  // spaced gap cycles rise to rise (gap must be at least 4)
  task automatic pulses(input int n, input int gap, input logic key);
    repeat (n) begin
      @(posedge hclk);
      if (key)
        drv.key_open <= 1'b1;
      else
        drv.reset_button <= 1'b1;
      repeat (3) @(posedge hclk);
      drv.key_open <= 1'b0;
      drv.reset_button <= 1'b0;
      repeat (gap - 4) @(posedge hclk);
    end
  endtask
endmodule

// ==== dv/shaft_access_interlock_tb_top.sv ====
// self-checking testbench of the shaft access interlock
`timescale 1ns/1ps
module shaft_access_interlock_tb_top;
  localparam logic [31:0] GAP_CYC  = 32'h0000_0032;
  localparam logic [31:0] COIL_CYC = 32'h0000_0010;
  localparam int          COIL_WT  = 20;

  logic                          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]                   haddr, hwdata, hrdata;
  logic [1:0]                    htrans;
  logic [2:0]                    hsize;
  shaft_access_pkg::shaft_pins_t pins;
  shaft_access_pkg::run_req_t    run_req;
  logic                          run_permit, shaft_protection_fault, green_light, red_light, reset_coil;
  logic [7:0]                    fault_code;
  int                            err_count, cmp_count;

  assign hready = hreadyout;

  shaft_access_interlock #(.QUICK_GAP_CYC(GAP_CYC), .COIL_PULSE_CYC(COIL_CYC)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pins(pins), .run_req(run_req), .run_permit(run_permit),
    .shaft_protection_fault(shaft_protection_fault), .fault_code(fault_code),
    .green_light(green_light), .red_light(red_light), .reset_coil(reset_coil));

  shaft_side_model i_side (.hclk(hclk), .reset_coil(reset_coil), .pins(pins));

  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // one compare for every kind of value, zero-extended to a word
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // single AHB-Lite word transfer; waits on hready, never assumes a latency
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    // only the watchdog ends a wait for hready
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0000_0000, rd);
    check(rd, exp);
    check({31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask

  // expected status word; the car is kept at rest, so green follows the fault
  function automatic logic [31:0] stat(input logic f, input logic [7:0] c);
    logic [31:0] s;
    s = 32'h0000_0000;
    s[shaft_access_pkg::STAT_FAULT_BIT] = f;
    s[shaft_access_pkg::STAT_CODE_LSB +: 8] = c;
    s[shaft_access_pkg::STAT_GREEN_BIT] = f;
    return s;
  endfunction

  // bounded wait: pin synchroniser plus guard logic take a handful of cycles
  task automatic wait_fault(input logic v);
    int n;
    for (n = 0; n < 40 && shaft_protection_fault !== v; n++) @(posedge hclk);
    check({31'h0, shaft_protection_fault}, {31'h0, v});
  endtask

  task automatic run_chk(input logic [2:0] req, input logic exp);
    @(posedge hclk);
    run_req <= shaft_access_pkg::run_req_t'(req);
    repeat (3) @(posedge hclk);
    check({31'h0, run_permit}, {31'h0, exp});
    run_req <= shaft_access_pkg::run_req_t'(3'b000);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs several hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    err_count = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    run_req = shaft_access_pkg::run_req_t'(3'b000);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, unmapped place, idle lights and runs
    rd_chk(shaft_access_pkg::ADDR_CTRL, shaft_access_pkg::CTRL_RST);
    rd_chk(shaft_access_pkg::ADDR_GAP, GAP_CYC);
    rd_chk(shaft_access_pkg::ADDR_CMD, 32'h0000_0000);
    rd_chk(shaft_access_pkg::ADDR_STATUS, stat(1'b0, shaft_access_pkg::CODE_NONE));
    rd_chk(8'h10, 32'h0000_0000);
    // a shorter gap limit written by software is used by both pulse trains
    wr(shaft_access_pkg::ADDR_GAP, 32'h0000_0028);
    rd_chk(shaft_access_pkg::ADDR_GAP, 32'h0000_0028);
    check({31'h0, red_light}, 32'h0000_0001);
    run_chk(3'b100, 1'b1);
    // release key entry: code 21, normal run blocked, inspection allowed
    i_side.drv.key_open <= 1'b1;
    wait_fault(1'b1);
    i_side.drv.key_open <= 1'b0;
    rd_chk(shaft_access_pkg::ADDR_STATUS, stat(1'b1, shaft_access_pkg::CODE_KEY));
    check({31'h0, red_light}, 32'h0000_0000);
    run_chk(3'b100, 1'b0);
    run_chk(3'b011, 1'b1);
    // quick presses with a landing door open are refused
    i_side.drv.doors_closed <= 1'b0;
    i_side.pulses(3, 10, 1'b0);
    repeat (8) @(posedge hclk);
    check({31'h0, shaft_protection_fault}, 32'h0000_0001);
    i_side.drv.doors_closed <= 1'b1;
    repeat (60) @(posedge hclk);
    // presses spaced at the gap limit do not count as quick
    i_side.pulses(3, 40, 1'b0);
    repeat (8) @(posedge hclk);
    check({31'h0, shaft_protection_fault}, 32'h0000_0001);
    repeat (60) @(posedge hclk);
    // three quick presses clear the fault and pulse the landing coils
    i_side.pulses(3, 10, 1'b0);
    wait_fault(1'b0);
    check({31'h0, reset_coil}, 32'h0000_0001);
    rd_chk(shaft_access_pkg::ADDR_STATUS, 32'h0000_0001 << shaft_access_pkg::STAT_COIL_BIT);
    check({24'h0, fault_code}, {24'h0, shaft_access_pkg::CODE_NONE});
    repeat (COIL_WT) @(posedge hclk);
    check({31'h0, reset_coil}, 32'h0000_0000);
    // pit entry: code 20; green only with the car at rest
    i_side.drv.pit_chain_point_open <= 1'b1;
    wait_fault(1'b1);
    i_side.drv.pit_chain_point_open <= 1'b0;
    rd_chk(shaft_access_pkg::ADDR_STATUS, stat(1'b1, shaft_access_pkg::CODE_PIT));
    i_side.drv.car_stopped <= 1'b0;
    repeat (6) @(posedge hclk);
    check({31'h0, green_light}, 32'h0000_0000);
    i_side.drv.car_stopped <= 1'b1;
    // programmer reset refused while the bistable contacts are shut
    wr(shaft_access_pkg::ADDR_CMD, 32'h0000_0001);
    repeat (8) @(posedge hclk);
    check({31'h0, shaft_protection_fault}, 32'h0000_0001);
    i_side.bist_r <= 1'b1;
    repeat (6) @(posedge hclk);
    wr(shaft_access_pkg::ADDR_CMD, 32'h0000_0001);
    wait_fault(1'b0);
    repeat (COIL_WT) @(posedge hclk);
    // contact recloses before any reset: coil circuit fault, then key cycles clear it
    i_side.drv.key_open <= 1'b1;
    wait_fault(1'b1);
    i_side.drv.key_open <= 1'b0;
    repeat (4) @(posedge hclk);
    i_side.bist_r <= 1'b0;
    repeat (8) @(posedge hclk);
    check({24'h0, fault_code}, {24'h0, shaft_access_pkg::CODE_COIL});
    i_side.bist_r <= 1'b1;
    repeat (60) @(posedge hclk);
    i_side.pulses(3, 10, 1'b1);
    wait_fault(1'b0);
    repeat (COIL_WT) @(posedge hclk);
    // monostable mode: internal circuit must be open for a reset
    wr(shaft_access_pkg::ADDR_CTRL, 32'h0000_0001);
    rd_chk(shaft_access_pkg::ADDR_CTRL, 32'h0000_0001);
    i_side.drv.key_open <= 1'b1;
    wait_fault(1'b1);
    i_side.drv.key_open <= 1'b0;
    wr(shaft_access_pkg::ADDR_CMD, 32'h0000_0001);
    repeat (8) @(posedge hclk);
    check({24'h0, fault_code}, {24'h0, shaft_access_pkg::CODE_COIL});
    check({31'h0, shaft_protection_fault}, 32'h0000_0001);
    i_side.drv.internal_bist_open <= 1'b1;
    repeat (6) @(posedge hclk);
    wr(shaft_access_pkg::ADDR_CMD, 32'h0000_0001);
    wait_fault(1'b0);
    tally_and_finish();
  end
endmodule
